//--- hw/timer16_core.v
/*
 * 16-bit timer/counter: normal, clear-on-compare and fast PWM modes,
 * with Avalon-MM register slave and prescaler.
 * Assumes one clock; interrupt execution is signalled by vector_ack.
 */
`timescale 1ns/10ps
`include "timer16_map.vh"

// What this block does
// R1: mode field alone sets counting sequence
// R2: non-PWM: set, clear or toggle on match
// R3: output mode zero means no action
// R4: normal mode counts up, wraps at FFFF
// R5: normal: overflow flag set when counter hits zero
// R6: overflow flag cleared on interrupt execution
// R7: modes 4/C clear at compare A/capture
// R8: clear-on-compare TOP unbuffered, low TOP wraps
// R9: toggle mode toggles output A every match, in fast PWM only in mode F
// R10: pin driven only when direction is output
// R11: prescaler divides by 1, 8, 64, 256, 1024
// R12: clear-on-compare overflow at MAX to zero
// R13: reaching TOP raises compare A/capture flag
// R14: fast PWM TOP fixed, capture or compare A
// R15: fast PWM clear on match, set at bottom
// R16: codes 2 and 3 give opposite polarities
// R17: software keeps TOP >= 3 and >= compares
// R18: fast PWM overflow and TOP flag together
// R19: fixed TOP masks compare bits on write
// R20: capture TOP unbuffered, low value wraps
// R21: fast PWM compare A buffered, loads at TOP
// R22: compare zero spikes, compare TOP constant
// R23: mode F toggle gives 50 percent duty
// R24: counter advances only on prescaler ticks

module timer16_core (
    input wire clock,
    input wire rst,
    input wire [5:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output reg waitrequest,
    input wire [2:0] vector_ack,
    output reg wave_out_a,
    output reg wave_out_a_oe,
    output reg overflow_flag,
    output reg compare_a_flag,
    output reg capture_flag
);

// ---------------------------------------------------------------
// registers
// ---------------------------------------------------------------
reg [3:0] waveform_gen_mode;
reg [1:0] compare_output_mode_a;
reg [2:0] presc_sel;
reg [15:0] counter_value;
reg [15:0] compare_a_value;
reg [15:0] compare_a_buffer;
reg [15:0] capture_value;
reg pin_direction_a;
reg wave_state;
reg ack_done_reg;
wire tick;

timer_prescaler u_presc (
    .clock(clock),
    .rst(rst),
    .select(presc_sel),
    .tick(tick)
);

// ---------------------------------------------------------------
// mode decode
// ---------------------------------------------------------------
reg is_pwm;
reg is_clear;
reg [15:0] top_value;
reg [15:0] fixed_mask;
reg top_is_cmpa;
reg top_is_capt;

always @* begin
    is_pwm = 1'b0;
    is_clear = 1'b0;
    top_value = `COUNT_MAX;
    fixed_mask = `COUNT_MAX;
    top_is_cmpa = 1'b0;
    top_is_capt = 1'b0;
    case (waveform_gen_mode) // see R1
        `WGM_CLEAR_CMPA: begin
            is_clear = 1'b1;
            top_value = compare_a_value; // see R7
            top_is_cmpa = 1'b1;
        end
        `WGM_CLEAR_CAPT: begin
            is_clear = 1'b1;
            top_value = capture_value; // see R7
            top_is_capt = 1'b1;
        end
        `WGM_FPWM_8: begin
            is_pwm = 1'b1;
            top_value = `TOP_8BIT; // see R14
            fixed_mask = `TOP_8BIT;
        end
        `WGM_FPWM_9: begin
            is_pwm = 1'b1;
            top_value = `TOP_9BIT; // see R14
            fixed_mask = `TOP_9BIT;
        end
        `WGM_FPWM_10: begin
            is_pwm = 1'b1;
            top_value = `TOP_10BIT; // see R14
            fixed_mask = `TOP_10BIT;
        end
        `WGM_FPWM_CAPT: begin
            is_pwm = 1'b1;
            top_value = capture_value; // see R14 R20
            top_is_capt = 1'b1;
        end
        `WGM_FPWM_CMPA: begin
            is_pwm = 1'b1;
            top_value = compare_a_value; // see R14
            top_is_cmpa = 1'b1;
        end
        default: begin
            top_value = `COUNT_MAX; // see R4
        end
    endcase
end

// ---------------------------------------------------------------
// register select
// ---------------------------------------------------------------
// a write lands at the edge where waitrequest is sampled low
wire wr_done = write && !waitrequest;
wire sel_control = (address == `OFS_CONTROL);
wire sel_counter = (address == `OFS_COUNTER);
wire sel_compare_a = (address == `OFS_COMPARE_A);
wire sel_capture = (address == `OFS_CAPTURE);
wire sel_flags = (address == `OFS_FLAGS);
wire sel_direction = (address == `OFS_DIRECTION);

// ---------------------------------------------------------------
// counting and events
// ---------------------------------------------------------------
wire at_top = (counter_value == top_value);
wire at_max = (counter_value == `COUNT_MAX);
wire match_a = (counter_value == compare_a_value);
// early clear only in clear/PWM modes; a low TOP is passed by, see R8 R20
wire clear_now = tick && (is_clear || is_pwm) && at_top;
// a TOP of FFFF clears and wraps at once; both count as overflow
wire wrap_now = tick && at_max; // see R4 R12
wire cnt_write = wr_done && sel_counter;
wire ovf_event = is_pwm ? clear_now : wrap_now; // see R5 R12 R18
wire top_event = (is_clear || is_pwm) && clear_now; // see R13 R18
wire cmpa_event = tick && match_a;
wire capt_event = top_event && top_is_capt;
wire cmpa_flag_event = top_is_cmpa ? top_event : cmpa_event;

always @(posedge clock or posedge rst) begin
    if (rst) begin
        counter_value <= `RESET_ZERO16;
    end else if (cnt_write) begin
        counter_value <= writedata[15:0];
    end else if (clear_now) begin
        counter_value <= `COUNT_BOTTOM; // see R7 R14
    end else if (tick) begin
        counter_value <= counter_value + 16'h0001; // see R24 R4
    end
end

// ---------------------------------------------------------------
// waveform generator
// ---------------------------------------------------------------
reg wave_next;

always @* begin
    wave_next = wave_state;
    if (tick) begin
        if (!is_pwm) begin
            if (match_a) begin
                case (compare_output_mode_a) // see R2 R3
                    `COM_TOGGLE: wave_next = ~wave_state; // see R9
                    `COM_PWM_NONINV: wave_next = 1'b0;
                    `COM_PWM_INV: wave_next = 1'b1;
                    default: wave_next = wave_state;
                endcase
            end
        end else begin
            // mode 3 inverts mode 2, match wins over bottom, see R16 R22
            case (compare_output_mode_a)
                `COM_TOGGLE: begin
                    if (match_a && waveform_gen_mode == `WGM_FPWM_CMPA)
                        wave_next = ~wave_state; // see R23
                end
                `COM_PWM_NONINV: begin
                    if (match_a)
                        wave_next = 1'b0; // see R15
                    else if (clear_now)
                        wave_next = 1'b1;
                end
                `COM_PWM_INV: begin
                    if (match_a)
                        wave_next = 1'b1; // see R15
                    else if (clear_now)
                        wave_next = 1'b0;
                end
                default: wave_next = wave_state; // see R3
            endcase
        end
    end
end

always @(posedge clock or posedge rst) begin
    if (rst) begin
        wave_state <= 1'b0;
    end else begin
        wave_state <= wave_next;
    end
end

// ---------------------------------------------------------------
// pin outputs
// ---------------------------------------------------------------
// level and drive enable leave together from flip-flops
always @(posedge clock or posedge rst) begin
    if (rst) begin
        wave_out_a <= 1'b0;
        wave_out_a_oe <= 1'b0;
    end else begin
        wave_out_a <= wave_next;
        wave_out_a_oe <= pin_direction_a; // see R10
    end
end

// ---------------------------------------------------------------
// flags: set wins over clear
// ---------------------------------------------------------------
wire flag_wr = wr_done && sel_flags;

always @(posedge clock or posedge rst) begin
    if (rst) begin
        overflow_flag <= 1'b0;
        compare_a_flag <= 1'b0;
        capture_flag <= 1'b0;
    end else begin
        if (ovf_event)
            overflow_flag <= 1'b1; // see R5
        else if (vector_ack[`FLG_OVERFLOW] ||
                 (flag_wr && writedata[`FLG_OVERFLOW]))
            overflow_flag <= 1'b0; // see R6
        if (cmpa_flag_event)
            compare_a_flag <= 1'b1; // see R13
        else if (vector_ack[`FLG_COMPARE_A] ||
                 (flag_wr && writedata[`FLG_COMPARE_A]))
            compare_a_flag <= 1'b0;
        if (capt_event)
            capture_flag <= 1'b1; // see R13
        else if (vector_ack[`FLG_CAPTURE] ||
                 (flag_wr && writedata[`FLG_CAPTURE]))
            capture_flag <= 1'b0;
    end
end

// ---------------------------------------------------------------
// compare and capture registers
// ---------------------------------------------------------------
wire cmpa_wr = wr_done && sel_compare_a;
wire capt_wr = wr_done && sel_capture;

always @(posedge clock or posedge rst) begin
    if (rst) begin
        compare_a_value <= `RESET_ZERO16;
        compare_a_buffer <= `RESET_ZERO16;
        capture_value <= `RESET_ZERO16;
    end else begin
        if (cmpa_wr)
            compare_a_buffer <= writedata[15:0] & fixed_mask; // see R19
        if (!is_pwm) begin
            if (cmpa_wr)
                compare_a_value <= writedata[15:0] & fixed_mask; // see R8
            else
                compare_a_value <= compare_a_buffer;
        end else if (clear_now) begin
            compare_a_value <= compare_a_buffer; // see R21
        end
        if (capt_wr)
            capture_value <= writedata[15:0]; // see R20
    end
end

// ---------------------------------------------------------------
// Avalon-MM slave: one wait cycle per access
// ---------------------------------------------------------------
always @(posedge clock or posedge rst) begin
    if (rst) begin
        waveform_gen_mode <= `WGM_NORMAL;
        compare_output_mode_a <= `COM_NONE;
        presc_sel <= `PRESC_STOP;
        pin_direction_a <= 1'b0;
        waitrequest <= 1'b1;
        readdata <= 32'h00000000;
        ack_done_reg <= 1'b0;
    end else begin
        waitrequest <= 1'b1;
        ack_done_reg <= 1'b0;
        // a held request is answered every other cycle: idle cycle after each answer
        if ((read || write) && waitrequest && !ack_done_reg) begin
            waitrequest <= 1'b0;
            ack_done_reg <= 1'b1;
            readdata <= 32'h00000000;
            if (read) begin
                case (address)
                    `OFS_CONTROL: readdata <= {21'h000000,
                        presc_sel, 2'h0, compare_output_mode_a,
                        waveform_gen_mode};
                    `OFS_COUNTER: readdata <= {16'h0000,
                        counter_value};
                    `OFS_COMPARE_A: readdata <= {16'h0000,
                        compare_a_buffer};
                    `OFS_CAPTURE: readdata <= {16'h0000,
                        capture_value};
                    `OFS_FLAGS: readdata <= {29'h00000000, capture_flag,
                        compare_a_flag, overflow_flag};
                    `OFS_DIRECTION: readdata <= {31'h00000000,
                        pin_direction_a};
                    default: readdata <= 32'h00000000;
                endcase
            end
        end
        if (write && !waitrequest) begin
            if (sel_control) begin
                waveform_gen_mode <= writedata[`CTL_WGM_MSB:`CTL_WGM_LSB];
                compare_output_mode_a <=
                    writedata[`CTL_COM_MSB:`CTL_COM_LSB];
                presc_sel <= writedata[`CTL_PRESC_MSB:`CTL_PRESC_LSB];
            end
            if (sel_direction)
                pin_direction_a <= writedata[0];
        end
    end
end

endmodule // timer16_core

//--- hw/timer16_map.vh
/*
 * Register offsets, field positions, reset values and mode codes of the
 * 16-bit timer/counter. Assumes a 32-bit Avalon-MM slave, word-aligned.
 */
`ifndef TIMER16_MAP_VH
`define TIMER16_MAP_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_CONTROL 6'h00
`define OFS_COUNTER 6'h04
`define OFS_COMPARE_A 6'h08
`define OFS_CAPTURE 6'h0C
`define OFS_FLAGS 6'h10
`define OFS_DIRECTION 6'h14

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define CTL_WGM_LSB 0
`define CTL_WGM_MSB 3
`define CTL_COM_LSB 4
`define CTL_COM_MSB 5
`define CTL_PRESC_LSB 8
`define CTL_PRESC_MSB 10

// flag register fields
`define FLG_OVERFLOW 0
`define FLG_COMPARE_A 1
`define FLG_CAPTURE 2

// ---------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------
`define WGM_NORMAL 4'h0
`define WGM_CLEAR_CMPA 4'h4
`define WGM_FPWM_8 4'h5
`define WGM_FPWM_9 4'h6
`define WGM_FPWM_10 4'h7
`define WGM_CLEAR_CAPT 4'hC
`define WGM_FPWM_CAPT 4'hE
`define WGM_FPWM_CMPA 4'hF

`define COM_NONE 2'h0
`define COM_TOGGLE 2'h1
`define COM_PWM_NONINV 2'h2
`define COM_PWM_INV 2'h3

`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define COUNT_MAX 16'hFFFF
`define COUNT_BOTTOM 16'h0000

// prescaler selects: 0 stops, 1..5 are /1 /8 /64 /256 /1024
`define PRESC_STOP 3'h0
`define PRESC_DIV1 3'h1
`define PRESC_DIV8 3'h2
`define PRESC_DIV64 3'h3
`define PRESC_DIV256 3'h4
`define PRESC_DIV1024 3'h5
`define PRESC_WIDTH 10

`define RESET_ZERO16 16'h0000
`endif

//--- hw/timer_prescaler.v
/*
 * Prescaler: one-cycle tick on clock every N cycles, N from select.
 * Assumes select is stable or changes take effect at once, mid-period.
 */
`timescale 1ns/10ps
`include "timer16_map.vh"

module timer_prescaler (
    input wire clock,
    input wire rst,
    input wire [2:0] select,
    output reg tick
);

reg [9:0] div_reg;
reg hit;

always @* begin
    case (select)
        `PRESC_DIV1: hit = 1'b1;
        `PRESC_DIV8: hit = (div_reg[2:0] == 3'h7);
        `PRESC_DIV64: hit = (div_reg[5:0] == 6'h3F);
        `PRESC_DIV256: hit = (div_reg[7:0] == 8'hFF);
        `PRESC_DIV1024: hit = (div_reg == 10'h3FF);
        default: hit = 1'b0;
    endcase
end

always @(posedge clock or posedge rst) begin
    if (rst) begin
        div_reg <= 10'h000;
        tick <= 1'b0;
    end else begin
        div_reg <= (select == `PRESC_STOP) ? 10'h000 : div_reg + 10'h001;
        tick <= hit; // see R11
    end
end

endmodule // timer_prescaler

//--- verification/timer16_core_props.sv
/*
 * Port checker for the 16-bit timer: bus handshake, flag clearing,
 * pin direction and read data shape.
 * Assumes it is bound to every timer16_core instance.
 */
`timescale 1ns/10ps
module timer16_core_props (
    input wire clock,
    input wire rst,
    input wire [5:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire [2:0] vector_ack,
    input wire wave_out_a,
    input wire wave_out_a_oe,
    input wire overflow_flag,
    input wire compare_a_flag,
    input wire capture_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire flag_wr = write && !waitrequest && address == 6'h10;
    wire dir_wr = write && !waitrequest && address == 6'h14;
    a_wait_one: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low two cycles");
    a_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
        else $error("answer without request");
    a_ovf_clear: assert property ($fell(overflow_flag) |->
        $past(vector_ack[0]) || $past(flag_wr && writedata[0]))
        else $error("overflow flag cleared without cause");
    a_cmpa_clear: assert property ($fell(compare_a_flag) |->
        $past(vector_ack[1]) || $past(flag_wr && writedata[1]))
        else $error("compare flag cleared without cause");
    a_capt_clear: assert property ($fell(capture_flag) |->
        $past(vector_ack[2]) || $past(flag_wr && writedata[2]))
        else $error("capture flag cleared without cause");
    a_dir_hold: assert property ($changed(wave_out_a_oe) |->
        $past(dir_wr, 2))
        else $error("drive enable changed without write");
    a_dir_value: assert property ($past(dir_wr, 2) |->
        wave_out_a_oe == $past(writedata[0], 2))
        else $error("drive enable not taken from write");
    a_upper_zero: assert property (read && !waitrequest |->
        readdata[31:16] == 16'h0000) else $error("upper read bits set");
    a_unmapped_zero: assert property (read && !waitrequest &&
        address > 6'h14 |-> readdata == 32'h00000000)
        else $error("unmapped read not zero");
endmodule // timer16_core_props

bind timer16_core timer16_core_props i_props (.clock(clock), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .vector_ack(vector_ack),
    .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
    .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag),
    .capture_flag(capture_flag));

//--- verification/timer16_core_tb.sv
/*
 * Self-checking bench for the 16-bit timer: modes, flags, waveform.
 * Assumes the register map and one-wait-state bus of the core.
 */
`timescale 1ns/10ps
module timer16_core_tb;
    reg clock = 0;
    reg rst = 1;
    reg [5:0] address = 6'h00;
    reg read = 0;
    reg write = 0;
    reg [31:0] writedata = 32'h00000000;
    reg [2:0] vector_ack = 3'h0;
    wire [31:0] readdata;
    wire waitrequest, wave_out_a, wave_out_a_oe;
    wire overflow_flag, compare_a_flag, capture_flag;
    integer num_errors = 0, comparisons = 0, cyc = 0;
    integer i, c, t, tp, hi;
    reg [31:0] q;
    reg [1:0] com;

    always #25 clock = ~clock;
    timer16_core i_timer16_core (.clock(clock), .rst(rst),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .vector_ack(vector_ack),
        .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
        .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag),
        .capture_flag(capture_flag));

    // ----------------------------------------------------------
    // tasks
    // ----------------------------------------------------------
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", comparisons, num_errors);
            if (num_errors == 0 && comparisons > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors = num_errors + 1;
            report_and_stop;
        end
    end

    task check(input string name, input [31:0] exp, input [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD %s exp %h got %h", name, exp, got);
            end
        end
    endtask

    task bus(input w, input [5:0] a, input [31:0] d);
        begin
            @(posedge clock);
            address <= a;
            write <= w;
            read <= !w;
            writedata <= d;
            @(posedge clock);
            while (waitrequest !== 1'b0) @(posedge clock);
            q = readdata;
            write <= 0;
            read <= 0;
        end
    endtask

    task setup(input [3:0] md, input [1:0] cm, input [2:0] ps,
               input [15:0] cmp, input [15:0] cap, input [15:0] cnt);
        begin
            bus(1, 6'h00, {21'h000000, 3'h0, 2'h0, cm, md});
            bus(1, 6'h08, {16'h0000, cmp});
            bus(1, 6'h0C, {16'h0000, cap});
            bus(1, 6'h04, {16'h0000, cnt});
            bus(1, 6'h00, {21'h000000, ps, 2'h0, cm, md});
        end
    endtask

    // cycles between two changes of the waveform
    task half;
        reg p;
        begin
            repeat (2) begin
                p = wave_out_a;
                t = 0;
                while (wave_out_a === p && t < 9000) begin
                    @(negedge clock);
                    t = t + 1;
                end
            end
        end
    endtask

    task hicount(input integer w);
        begin
            hi = 0;
            repeat (w) begin
                @(negedge clock);
                if (wave_out_a === 1'b1) hi = hi + 1;
            end
        end
    endtask

    function integer div(input [2:0] p);
        case (p)
            3'h1: div = 1;
            3'h2: div = 8;
            3'h3: div = 64;
            3'h4: div = 256;
            default: div = 1024;
        endcase
    endfunction

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        q = $urandom(32'h28EE);
        repeat (16) @(posedge clock);
        rst <= 0;
        bus(0, 6'h04, 0); check("count_rst", 0, q);
        bus(0, 6'h10, 0); check("flags_rst", 0, q);
        bus(0, 6'h18, 0); check("unmapped", 0, q);
        check("oe_rst", 0, wave_out_a_oe);
        bus(1, 6'h14, 1);
        repeat (2) @(negedge clock);
        check("oe", 1, wave_out_a_oe);
        $display("test reset done");
        setup(4'h0, 2'h0, 3'h1, 0, 0, 16'hFFD0);
        check("ovf_early", 0, overflow_flag);
        repeat (64) @(posedge clock);
        check("ovf_wrap", 1, overflow_flag);
        bus(0, 6'h04, 0); check("wrapped", 1, q < 256);
        @(posedge clock) vector_ack <= 3'h7;
        @(posedge clock) vector_ack <= 3'h0;
        repeat (2) @(posedge clock);
        check("ovf_ack", 0, overflow_flag);
        $display("test normal done");
        c = 3 + $urandom % 20;
        bus(1, 6'h10, 7);
        setup(4'h4, 2'h1, 3'h1, c, 0, 16'hFFE0);
        repeat (100) @(posedge clock);
        check("clr_ovf", 1, overflow_flag);
        check("clr_cmpa", 1, compare_a_flag);
        check("clr_capt", 0, capture_flag);
        half; check("clr_half", c + 1, t);
        bus(0, 6'h04, 0); check("clr_cnt", 1, q <= c);
        setup(4'hC, 2'h0, 3'h1, 16'hFFFF, c, 0);
        bus(1, 6'h10, 7);
        com = wave_out_a;
        repeat (100) @(posedge clock);
        check("clr2_capt", 1, capture_flag);
        check("clr2_cmpa", 0, compare_a_flag);
        check("clr2_hold", com, wave_out_a);
        $display("test clear_on_compare done");
        for (i = 0; i < 7; i = i + 1) begin
            tp = (i < 6) ? (256 << (i / 2)) - 1 : 20 + $urandom % 100;
            com = 2'h2 + i % 2;
            c = (i == 0) ? 0 : $urandom % 65536;
            if ((c & tp) == tp) c = c ^ 1;
            if (i < 6) setup(4'h5 + i / 2, com, 3'h1, c, 0, 0);
            else setup(4'hE, com, 3'h1, c % tp, tp, 0);
            c = (i == 6) ? c % tp : c & tp;
            bus(0, 6'h08, 0); check("cmp_mask", c, q);
            repeat (2 * tp + 64) @(posedge clock);
            hicount(tp + 1);
            check("pwm_hi", com == 2'h2 ? c + 1 : tp - c, hi);
        end
        $display("test fast_pwm done");
        for (i = 1; i < 6; i = i + 1) begin
            setup(4'hF, 2'h1, i, 3, 0, 0);
            half; half; check("tog_half", 4 * div(i), t);
        end
        bus(1, 6'h10, 7);
        t = 0;
        while (overflow_flag !== 1'b1 && t < 9000) begin
            @(posedge clock);
            t = t + 1;
        end
        check("top_ovf", 1, overflow_flag);
        check("top_flags", 1, compare_a_flag);
        $display("test toggle done");
        report_and_stop;
    end
endmodule // timer16_core_tb
